// File: hdl/srseq_pkg.sv
// Shared constants, types and opcodes for the subroutine return sequencer
package srseq_pkg;
   localparam int PC_W   = 13;
   localparam int WORD_W = 14;
   localparam int DATA_W = 8;
   localparam int DEPTH  = 8;
   localparam int PTR_W  = 3;

   // Opcode encodings of the three returns (14-bit words)
   localparam logic [13:0] OP_RET_IRQ  = 14'h0009;
   localparam logic [13:0] OP_RET_SUB  = 14'h0008;
   localparam logic [5:0]  OP_RET_LIT  = 6'h34;   // Upper six bits, low byte is literal
   localparam int          LIT_HI_MSB  = 13;
   localparam int          LIT_HI_LSB  = 8;

   // Interrupt control register layout
   localparam int          GIE_BIT     = 7;
   localparam logic [7:0]  INTERRUPT_CONTROL_REG_RST  = 8'h00;
   localparam logic [12:0] PC_RST      = 13'h0000;
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [2:0]  PTR_RST     = 3'h0;
   localparam logic [2:0]  PTR_ONE     = 3'h1;

   typedef enum logic [2:0] {
      SRSEQ_IDLE  = 3'b001,
      SRSEQ_POP   = 3'b010,
      SRSEQ_FLUSH = 3'b100
   } srseq_state_t;

   typedef enum logic [2:0] {
      SRSEQ_K_NONE = 3'b000,
      SRSEQ_K_IRQ  = 3'b001,
      SRSEQ_K_LIT  = 3'b010,
      SRSEQ_K_SUB  = 3'b100
   } srseq_kind_t;

   // Instruction issued from decode
   typedef struct packed {
      logic              valid;
      logic [13:0]       word;
   } srseq_instr_t;

   // Push request from call or interrupt entry
   typedef struct packed {
      logic              valid;
      logic [12:0]       addr;
   } srseq_push_t;

   // State of the top module
   typedef struct packed {
      srseq_state_t      state;
      srseq_kind_t       kind;
      logic [12:0]       pc;
      logic [7:0]        acc;
      logic [7:0]        interrupt_control_reg;
      logic [2:0]        ptr;
      logic              done;
      logic              pop;
   } srseq_regs_t;
endpackage

// File: hdl/srseq_stack.sv
// Return-address stack memory with registered top-of-stack read
`timescale 1ns/1ns
module srseq_stack
(
   // Clock and enable
   input  wire logic        clk,
   input  wire logic        ce,
   // Write port
   input  wire logic        wr_en,
   input  wire logic [2:0]  wr_addr,
   input  wire logic [12:0] wr_data,
   // Read port
   input  wire logic [2:0]  rd_addr,
   output logic      [12:0] rd_data
);
   logic [12:0] mem [srseq_pkg::DEPTH];

   // Storage needs no reset; content is defined by pushes
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (wr_en)
            mem[wr_addr] <= wr_data;
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// File: hdl/srseq_top.sv
// Return instruction sequencer: pops stack into PC, loads literal, sets irq enable
`timescale 1ns/1ns
// Overview of operation
// - Return from interrupt pops the stack and loads the popped top value into the program counter.
// - Return from interrupt sets the global interrupt enable, bit 7 of the interrupt control register.
// - Return from interrupt is a single program word completing in two instruction cycles.
// - Return with literal writes its 8-bit immediate into the accumulator.
// - Return with literal also pops the stack into the program counter.
// - Return with literal is a single program word completing in two instruction cycles.
// - Return from subroutine pops the stack into the program counter and changes nothing else.
// - Return from subroutine is a single program word completing in two instruction cycles.
module srseq_top
(
   // Clock, reset, enable
   input  wire logic                   CLK,
   input  wire logic                   RST,
   input  wire logic                   CE,
   // Decoded instruction and stack pushes
   input  srseq_pkg::srseq_instr_t     INSTR,
   input  srseq_pkg::srseq_push_t      PUSH,
   // Architectural state
   output logic                 [12:0] PC,
   output logic                 [7:0]  ACC,
   output logic                 [7:0]  INTERRUPT_CONTROL_REG,
   output logic                 [2:0]  STACK_PTR,
   output logic                        GLOBAL_IRQ_ENABLE,
   // Status flag write enable, never asserted here
   output logic                        STATUS_WE,
   // Sequencing handshake
   output logic                        BUSY,
   output logic                        FLUSH,
   output logic                        DONE,
   output logic                        POP
);
   // State register and its next value
   srseq_pkg::srseq_regs_t r_reg;
   srseq_pkg::srseq_regs_t r_next;

   // Decode and stack helpers
   srseq_pkg::srseq_kind_t kind_dec;
   logic [12:0]            stack_top;
   logic [2:0]             top_addr;
   logic [2:0]             ptr_up;
   logic                   accept;
   logic                   push_take;
   logic                   is_irq;
   logic                   is_sub;
   logic                   is_lit;
   logic [7:0]             lit_value;
   logic [7:0]             interrupt_control_reg_set;

   // Opcode matches; the literal return compares only its upper six bits
   assign is_irq    = INSTR.word == srseq_pkg::OP_RET_IRQ;
   assign is_sub    = INSTR.word == srseq_pkg::OP_RET_SUB;
   assign is_lit    = INSTR.word[srseq_pkg::LIT_HI_MSB:srseq_pkg::LIT_HI_LSB] == srseq_pkg::OP_RET_LIT;
   assign lit_value = INSTR.word[srseq_pkg::DATA_W-1:0];

   // Classify the incoming word; the exact matches are tested first
   always_comb
   begin
      kind_dec = srseq_pkg::SRSEQ_K_NONE;
      if (INSTR.valid)
      begin
         if (is_irq)
            kind_dec = srseq_pkg::SRSEQ_K_IRQ;
         else if (is_sub)
            kind_dec = srseq_pkg::SRSEQ_K_SUB;
         else if (is_lit)
            kind_dec = srseq_pkg::SRSEQ_K_LIT;
      end
   end

   // Only one word accepted while idle; a return is a single program word
   assign accept    = (r_reg.state == srseq_pkg::SRSEQ_IDLE)
                   && (kind_dec != srseq_pkg::SRSEQ_K_NONE);
   // A push is dropped while busy and in the cycle a return wins
   assign push_take = PUSH.valid && (r_reg.state == srseq_pkg::SRSEQ_IDLE) && !accept;

   // Pointer after a push and after a pop; both wrap at the stack depth
   assign ptr_up    = r_reg.ptr + srseq_pkg::PTR_ONE;
   assign top_addr  = r_reg.ptr - srseq_pkg::PTR_ONE;

   // Enable bit forced high, the other control bits kept as they are
   for (genvar b = 0; b < srseq_pkg::DATA_W; b++)
   begin : g_interrupt_control_reg
      if (b == srseq_pkg::GIE_BIT)
      begin : g_enable
         assign interrupt_control_reg_set[b] = 1'b1;
      end
      else
      begin : g_keep
         assign interrupt_control_reg_set[b] = r_reg.interrupt_control_reg[b];
      end
   end

   // Registered read means top value is ready in the pop cycle
   srseq_stack u_stack
   (
      .clk     (CLK),
      .ce      (CE),
      .wr_en   (push_take),
      .wr_addr (r_reg.ptr),
      .wr_data (PUSH.addr),
      .rd_addr (top_addr),
      .rd_data (stack_top)
   );

   // Next-state logic
   always_comb
   begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      r_next.pop  = 1'b0;
      case (r_reg.state)
         srseq_pkg::SRSEQ_IDLE:
         begin
            if (accept)
            begin
               r_next.kind  = kind_dec;
               r_next.state = srseq_pkg::SRSEQ_POP;
               // Literal lands at once so it is in place before the target runs
               if (kind_dec == srseq_pkg::SRSEQ_K_LIT)
               begin
                  r_next.acc = lit_value;
               end
            end
            else if (push_take)
            begin
               // Only a call or an interrupt entry grows the stack
               r_next.ptr = ptr_up;
            end
            else
            begin
               // Idle with nothing taken: kind cleared, done and pop drop, every other register holds
               r_next.kind = srseq_pkg::SRSEQ_K_NONE;
            end
         end
         srseq_pkg::SRSEQ_POP:
         begin
            // Cycle one: top value into PC, pointer moves down
            r_next.pc    = stack_top;
            r_next.ptr   = top_addr;
            r_next.pop   = 1'b1;
            r_next.state = srseq_pkg::SRSEQ_FLUSH;
            // Side effects that differ per kind
            case (r_reg.kind)
               srseq_pkg::SRSEQ_K_IRQ:
               begin
                  r_next.interrupt_control_reg = interrupt_control_reg_set;
               end
               srseq_pkg::SRSEQ_K_LIT:
               begin
                  // Accumulator was loaded when the word was taken
                  r_next.interrupt_control_reg = r_reg.interrupt_control_reg;
               end
               srseq_pkg::SRSEQ_K_SUB:
               begin
                  // Plain return leaves every other register alone
                  r_next.interrupt_control_reg = r_reg.interrupt_control_reg;
               end
               default:
               begin
                  // No kind latched after an upset: abandon without popping
                  r_next.pc    = r_reg.pc;
                  r_next.ptr   = r_reg.ptr;
                  r_next.pop   = 1'b0;
                  r_next.state = srseq_pkg::SRSEQ_IDLE;
               end
            endcase
         end
         srseq_pkg::SRSEQ_FLUSH:
         begin
            // Cycle two: fetched word discarded, target fetched next
            r_next.state = srseq_pkg::SRSEQ_IDLE;
            r_next.kind  = srseq_pkg::SRSEQ_K_NONE;
            r_next.done  = 1'b1;
         end
         default:
         begin
            // Illegal state code: recover to idle and drop the kind
            r_next.state = srseq_pkg::SRSEQ_IDLE;
            r_next.kind  = srseq_pkg::SRSEQ_K_NONE;
         end
      endcase
   end

   // State register, frozen while CE is low; reset wins over the enable
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         // Stack words are left alone; the pointer alone empties it
         r_reg.state  <= srseq_pkg::SRSEQ_IDLE;
         r_reg.kind   <= srseq_pkg::SRSEQ_K_NONE;
         r_reg.pc     <= srseq_pkg::PC_RST;
         r_reg.acc    <= srseq_pkg::ACC_RST;
         r_reg.interrupt_control_reg <= srseq_pkg::INTERRUPT_CONTROL_REG_RST;
         r_reg.ptr    <= srseq_pkg::PTR_RST;
         r_reg.done   <= 1'b0;
         r_reg.pop    <= 1'b0;
      end
      else if (CE)
         r_reg <= r_next;
   end

   // Architectural state straight from the register
   assign PC                = r_reg.pc;
   assign ACC               = r_reg.acc;
   assign INTERRUPT_CONTROL_REG            = r_reg.interrupt_control_reg;
   assign STACK_PTR         = r_reg.ptr;
   assign GLOBAL_IRQ_ENABLE = r_reg.interrupt_control_reg[srseq_pkg::GIE_BIT];

   // Flags are never written by a return, not even the literal one
   assign STATUS_WE         = 1'b0;

   // Handshake: BUSY and FLUSH decoded from the state, DONE and POP from their own register bits; BUSY blocks new words
   assign BUSY              = r_reg.state != srseq_pkg::SRSEQ_IDLE;
   assign FLUSH             = r_reg.state == srseq_pkg::SRSEQ_FLUSH;
   assign DONE              = r_reg.done;
   assign POP               = r_reg.pop;
endmodule

// File: dv/srseq_top_asserts.sv
// Port checker for the return sequencer
`timescale 1ns/1ns
module srseq_top_asserts
(
   // Clock and control
   input logic CLK,
   input logic RST,
   input logic CE,
   // Requests
   input srseq_pkg::srseq_instr_t INSTR,
   input srseq_pkg::srseq_push_t PUSH,
   // State and handshake
   input logic [12:0] PC,
   input logic [7:0] ACC,
   input logic [7:0] INTERRUPT_CONTROL_REG,
   input logic [2:0] STACK_PTR,
   input logic GLOBAL_IRQ_ENABLE,
   input logic STATUS_WE,
   input logic BUSY,
   input logic FLUSH,
   input logic DONE,
   input logic POP
);
   logic take;
   // Return accepted at this edge
   assign take = CE && !BUSY && INSTR.valid && (INSTR.word == srseq_pkg::OP_RET_IRQ
      || INSTR.word == srseq_pkg::OP_RET_SUB || INSTR.word[13:8] == srseq_pkg::OP_RET_LIT);
   default clocking @(posedge CLK); endclocking
   // A frozen cycle stretches a return; such attempts are dropped
   default disable iff (RST || !CE);
   a_two_cycle_seq: assert property (take |=> BUSY && !FLUSH ##1 BUSY && FLUSH ##1 DONE && !BUSY)
      else $error("return length wrong");
   a_pop_pulse: assert property (take |=> !POP ##1 POP ##1 !POP)
      else $error("pop pulse wrong");
   a_ptr_pop: assert property (take |=> ##1 STACK_PTR == $past(STACK_PTR, 2) - 3'h1)
      else $error("stack not popped");
   a_irq_enable: assert property (take && INSTR.word == srseq_pkg::OP_RET_IRQ |=> ##1 INTERRUPT_CONTROL_REG[7] && GLOBAL_IRQ_ENABLE)
      else $error("irq enable not set");
   a_lit_acc: assert property (take && INSTR.word[13:8] == srseq_pkg::OP_RET_LIT |=> ACC == $past(INSTR.word[7:0]))
      else $error("literal not loaded");
   a_sub_quiet: assert property (take && INSTR.word == srseq_pkg::OP_RET_SUB |=> ($stable(ACC) && $stable(INTERRUPT_CONTROL_REG))[*2])
      else $error("sub return changed state");
   a_no_flags: assert property (!STATUS_WE)
      else $error("flags written");
   a_flush_once: assert property ($rose(FLUSH) |-> POP ##1 !FLUSH && !BUSY)
      else $error("flush cycle wrong");
   // Main scenarios reached
   c_irq: cover property (take && INSTR.word == srseq_pkg::OP_RET_IRQ);
   c_lit: cover property (take && INSTR.word[13:8] == srseq_pkg::OP_RET_LIT);
   c_sub: cover property (take && INSTR.word == srseq_pkg::OP_RET_SUB);
endmodule

bind srseq_top srseq_top_asserts chk (.*);

// File: dv/srseq_top_tb.sv
// Self-checking bench for the return sequencer
`timescale 1ns/1ns
module srseq_top_tb;
   logic CLK = 1'b0, RST = 1'b1, CE = 1'b1;
   srseq_pkg::srseq_instr_t INSTR = '0;
   srseq_pkg::srseq_push_t PUSH = '0;
   logic [12:0] PC;
   logic [7:0] ACC, INTERRUPT_CONTROL_REG;
   logic [2:0] STACK_PTR;
   logic GLOBAL_IRQ_ENABLE, STATUS_WE, BUSY, FLUSH, DONE, POP;
   logic [12:0] stk [8];
   logic [2:0] sp = 3'h0;
   logic ie = 1'b0;
   logic [7:0] acc_x = 8'h00;
   logic [12:0] pc_x = 13'h0000;
   logic [31:0] rs = 32'h5B4D;
   int n_fail = 0, n_checks = 0;
   srseq_top uut (.*);
   // Clock
   always #20 CLK = ~CLK;
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   // Expected accumulator after a return word
   function automatic logic [7:0] exp_acc(logic [13:0] w, logic [7:0] old);
      return (w[13:8] == srseq_pkg::OP_RET_LIT) ? w[7:0] : old;
   endfunction
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic push(logic [12:0] a);
      @(negedge CLK) PUSH = '{1'b1, a};
      stk[sp] = a;
      sp++;
      @(negedge CLK) PUSH.valid = 1'b0;
   endtask
   // Pushes offered while busy must be dropped
   task automatic ret(logic [13:0] w);
      @(negedge CLK) INSTR = '{1'b1, w};
      rs = xs(rs);
      PUSH = '{1'b1, rs[12:0]};
      acc_x = exp_acc(w, acc_x);
      ie = ie | (w == srseq_pkg::OP_RET_IRQ);
      sp--;
      pc_x = stk[sp];
      @(negedge CLK) INSTR.valid = 1'b0;
      chk("busy", BUSY, 1'b1);
      chk("acc", ACC, acc_x);
      @(negedge CLK) PUSH.valid = 1'b0;
      chk("pc", PC, pc_x);
      chk("ie", {INTERRUPT_CONTROL_REG[7], GLOBAL_IRQ_ENABLE}, {2{ie}});
      chk("flush", {FLUSH, POP}, 2'h3);
      @(negedge CLK);
      chk("done", {DONE, BUSY}, 2'h2);
      chk("ptr", STACK_PTR, sp);
      chk("interrupt_control_reg", INTERRUPT_CONTROL_REG, {ie, 7'h00});
   endtask
   // Main sequence with literal boundaries
   initial
   begin
      repeat (16) @(posedge CLK);
      @(negedge CLK) RST = 1'b0;
      chk("reset_acc", {ACC, INTERRUPT_CONTROL_REG}, 16'h0000);
      chk("reset_pc", {PC, STACK_PTR}, 16'h0000);
      for (int i = 0; i < 30; i++)
      begin
         rs = xs(rs);
         push(rs[12:0]);
         if (i % 4 == 0) push(rs[31:19]);
         case (i % 3)
            0: ret(srseq_pkg::OP_RET_IRQ);
            1: ret({srseq_pkg::OP_RET_LIT, i == 1 ? 8'hFF : i == 4 ? 8'h00 : rs[15:8]});
            default: ret(srseq_pkg::OP_RET_SUB);
         endcase
      end
      // Freeze a plain return half way: CE low must hold BUSY, FLUSH, POP and PC
      push(13'h1ABC);
      @(negedge CLK) INSTR = '{1'b1, srseq_pkg::OP_RET_SUB};
      @(negedge CLK) INSTR.valid = 1'b0;
      CE = 1'b0;
      repeat (3) @(negedge CLK);
      chk("freeze", {BUSY, FLUSH, POP, PC}, {3'h4, pc_x});
      CE = 1'b1;
      sp--;
      @(negedge CLK);
      chk("thaw", {FLUSH, PC}, {1'b1, stk[sp]});
      @(negedge CLK);
      chk("thaw_done", {DONE, BUSY, STACK_PTR}, {2'h2, sp});
      @(negedge CLK) INSTR = '{1'b1, 14'h0100};
      @(negedge CLK) INSTR.valid = 1'b0;
      chk("other", BUSY, 1'b0);
      chk("we", STATUS_WE, 1'b0);
      complete_run;
   end
   // Watchdog far beyond the few hundred cycles needed
   initial
   begin
      #200000;
      n_fail++;
      complete_run;
   end
endmodule
